// ===== rtl/dppr_top.sv
// digital pin port: data, direction, alternate functions and routing
//
// Behaviour
// - direction zero input, one drives data
// - pins six, seven carry pulse outputs
// - pins four, five serve serial memory
// - push-button pin never drives
// - optical pins become ports when unused
// - three-bit selectors at 0x2009 to 0x200E
// - selector acts only on general-purpose pins
// - selector codes pick counter clocks, interrupts
// - routing follows real pin level
// - same resource from pins is ORed
// - sixteen general pins plus four extras
// - all pins input after reset
// - segment count decides segment or pin
`timescale 1ns/1ns
module dppr_top
    import dppr_pkg::*;
(
    input wire logic mclk, // system clock, 10 MHz
    input wire logic rst, // async reset, high
    input wire dppr_sfr_req_t sfr, // sfr request
    output logic [7:0] sfr_rdata, // sfr read answer
    input wire dppr_xram_req_t xram, // i/o memory request
    output logic [7:0] xram_rdata, // i/o memory answer
    input wire dppr_cfg_t cfg, // loose configuration bits
    input wire dppr_alt_t alt, // alternate function sources
    input wire logic [NPIN-1:0] pin_in, // pin levels
    output logic [NPIN-1:0] pin_out, // pin drive value
    output logic [NPIN-1:0] pin_oe, // pin drive enable
    output logic [NPIN-1:0] seg_enable, // pin handed to segment driver
    output logic ee_sda_in, // sampled memory data line
    output dppr_res_t res // routed resources
);

    typedef struct packed {
        logic [7:0] data0;
        logic [7:0] data1;
        logic [7:0] data2;
        logic [7:0] dir0;
        logic [7:0] dir1;
        logic [7:0] dir2;
        logic [NPIN-1:0] sample;
        logic [NPIN-1:0] seg;
        logic [NPIN-1:0] out;
        logic [NPIN-1:0] oe;
        logic [NROUTE-1:0] gp;
        logic [7:0] rdata;
        logic sda_in;
    } dppr_top_st_t;

    dppr_top_st_t st_r;
    dppr_top_st_t st_nxt;
    logic [3*NROUTE-1:0] sel;

    // ==========================================================
    // segment allocation: lowest dual pins go to segments first
    function automatic logic [NPIN-1:0] seg_map(input logic [4:0] n);
        logic [4:0] rank;
        rank = 5'h00;
        seg_map = '0;
        for (int i = 0; i < NPIN; i++) begin
            if (DUAL_MASK[i]) begin
                seg_map[i] = (rank < n);
                rank = rank + 5'h01;
            end
        end
    endfunction

    // ==========================================================
    // register access and pin drive
    always_comb begin
        logic [NPIN-1:0] dir_all;
        logic [NPIN-1:0] data_all;
        dir_all = {st_r.dir2, st_r.dir1, st_r.dir0};
        data_all = {st_r.data2, st_r.data1, st_r.data0};
        st_nxt = st_r;
        st_nxt.sample = pin_in & PRESENT_MASK;
        st_nxt.sda_in = st_r.sample[PIN_EE_SDA];
        st_nxt.seg = seg_map(cfg.segment_count_setting);

        if (sfr.we) begin
            if (sfr.addr == ADDR_DATA0) begin
                st_nxt.data0 = sfr.wdata;
            end else if (sfr.addr == ADDR_DATA1) begin
                st_nxt.data1 = sfr.wdata;
            end else if (sfr.addr == ADDR_DATA2) begin
                st_nxt.data2 = sfr.wdata;
            end else if (sfr.addr == ADDR_DIR0) begin
                st_nxt.dir0 = sfr.wdata & DIR0_MASK;
            end else if (sfr.addr == ADDR_DIR1) begin
                st_nxt.dir1 = sfr.wdata & DIR1_MASK;
            end else if (sfr.addr == ADDR_DIR2) begin
                st_nxt.dir2 = sfr.wdata & DIR2_MASK;
            end
        end

        if (sfr.re) begin
            if (sfr.addr == ADDR_DATA0) begin
                st_nxt.rdata = st_r.sample[7:0];
            end else if (sfr.addr == ADDR_DATA1) begin
                st_nxt.rdata = st_r.sample[15:8];
            end else if (sfr.addr == ADDR_DATA2) begin
                st_nxt.rdata = st_r.sample[23:16];
            end else if (sfr.addr == ADDR_DIR0) begin
                st_nxt.rdata = st_r.dir0;
            end else if (sfr.addr == ADDR_DIR1) begin
                st_nxt.rdata = st_r.dir1;
            end else if (sfr.addr == ADDR_DIR2) begin
                st_nxt.rdata = st_r.dir2;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end

        // plain drive: direction one drives the data bit
        st_nxt.oe = dir_all & PRESENT_MASK & ~st_r.seg;
        st_nxt.out = data_all & st_nxt.oe;
        st_nxt.oe[PIN_PB] = 1'b0;
        st_nxt.out[PIN_PB] = 1'b0;

        // optical pins are ports only while the uart is idle
        if (cfg.optical_uart_used) begin
            st_nxt.oe[PIN_OPTICAL_RECEIVE_PIN] = 1'b0;
            st_nxt.oe[PIN_OPTICAL_TRANSMIT_PIN] = 1'b0;
            st_nxt.out[PIN_OPTICAL_RECEIVE_PIN] = 1'b0;
            st_nxt.out[PIN_OPTICAL_TRANSMIT_PIN] = 1'b0;
        end

        // pulse outputs replace the data bits when declared outputs
        if (st_nxt.oe[PIN_ENERGY_PULSE_OUT] && cfg.energy_pulse_enable) begin
            st_nxt.out[PIN_ENERGY_PULSE_OUT] = alt.energy_pulse_out;
        end
        if (st_nxt.oe[PIN_VPULSE] && cfg.reactive_pulse_enable) begin
            st_nxt.out[PIN_VPULSE] = alt.reactive_pulse_out;
        end

        // serial memory takes pins four and five over entirely
        if (cfg.ee_select) begin
            st_nxt.out[PIN_EE_SCK] = alt.ee_sck;
            st_nxt.oe[PIN_EE_SCK] = 1'b1;
            st_nxt.out[PIN_EE_SDA] = alt.ee_sda_out & alt.ee_sda_oe;
            st_nxt.oe[PIN_EE_SDA] = alt.ee_sda_oe;
        end

        // routable pins: present, not segment, not taken by optical uart or serial memory
        for (int i = 0; i < NROUTE; i++) begin
            st_nxt.gp[i] = PRESENT_MASK[i] & ~st_r.seg[i];
        end
        if (cfg.optical_uart_used) begin
            st_nxt.gp[PIN_OPTICAL_RECEIVE_PIN] = 1'b0;
            st_nxt.gp[PIN_OPTICAL_TRANSMIT_PIN] = 1'b0;
        end
        if (cfg.ee_select) begin
            st_nxt.gp[PIN_EE_SCK] = 1'b0;
            st_nxt.gp[PIN_EE_SDA] = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= '{data0: RST_DATA, data1: RST_DATA, data2: RST_DATA,
                      dir0: RST_DIR, dir1: RST_DIR, dir2: RST_DIR,
                      default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sfr_rdata = st_r.rdata;
    assign pin_out = st_r.out;
    assign pin_oe = st_r.oe;
    assign seg_enable = st_r.seg;
    assign ee_sda_in = st_r.sda_in;

    // ==========================================================
    // selector storage and routing of sampled pin levels
    dppr_selram #(
        .N(NROUTE)
    ) u_selram (
        .mclk(mclk),
        .rst(rst),
        .xram(xram),
        .sel(sel),
        .xram_rdata(xram_rdata)
    );

    dppr_route #(
        .N(NROUTE)
    ) u_route (
        .mclk(mclk),
        .rst(rst),
        .level(st_r.sample[NROUTE-1:0]),
        .gp(st_r.gp),
        .sel(sel),
        .res(res)
    );

    // ==========================================================
    // checks
    logic dir_written_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dir_written_r <= 1'b0;
        end else if (sfr.we && (sfr.addr == ADDR_DIR0 || sfr.addr == ADDR_DIR1
                     || sfr.addr == ADDR_DIR2)) begin
            dir_written_r <= 1'b1;
        end
    end

    default clocking dcb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_pb_input;
        !pin_oe[PIN_PB];
    endproperty
    a_pb_input: assert property (p_pb_input) else $error("push-button driven");

    sequence s_dir0_write;
        sfr.we && sfr.addr == ADDR_DIR0;
    endsequence

    property p_dir_drive;
        s_dir0_write ##1 !sfr.we[*1] |=> pin_oe[PIN_DEDICATED] == $past(sfr.wdata[3], 2);
    endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("direction not applied");

    property p_data_drive;
        pin_oe[PIN_DEDICATED] |-> pin_out[PIN_DEDICATED] == $past(st_r.data0[3]);
    endproperty
    a_data_drive: assert property (p_data_drive) else $error("data bit not driven");

    property p_energy_pulse_out;
        $past(cfg.energy_pulse_enable && st_r.dir0[PIN_ENERGY_PULSE_OUT] && !st_r.seg[PIN_ENERGY_PULSE_OUT])
        |-> pin_out[PIN_ENERGY_PULSE_OUT] == $past(alt.energy_pulse_out);
    endproperty
    a_energy_pulse_out: assert property (p_energy_pulse_out) else $error("energy pulse not routed");

    property p_ee_sck;
        $past(cfg.ee_select) |-> pin_oe[PIN_EE_SCK] && pin_out[PIN_EE_SCK] == $past(alt.ee_sck);
    endproperty
    a_ee_sck: assert property (p_ee_sck) else $error("memory clock not on pin");

    property p_opt_release;
        $past(cfg.optical_uart_used) |-> !pin_oe[PIN_OPTICAL_RECEIVE_PIN] && !pin_oe[PIN_OPTICAL_TRANSMIT_PIN];
    endproperty
    a_opt_release: assert property (p_opt_release) else $error("optical pin driven");

    property p_reset_input;
        pin_oe != '0 |-> $past(dir_written_r) || $past(cfg.ee_select);
    endproperty
    a_reset_input: assert property (p_reset_input) else $error("output before direction");

    property p_read_sample;
        sfr.re && sfr.addr == ADDR_DATA0 |=> sfr_rdata == $past(pin_in[7:0], 2);
    endproperty
    a_read_sample: assert property (p_read_sample) else $error("data read not pin level");

endmodule

// ===== rtl/dppr_pkg.sv
// package: constants and carrier types for the digital pin port router
package dppr_pkg;

    // ==========================================================
    // pin population
    localparam int NPIN = 24;
    localparam int NROUTE = 12;
    localparam logic [23:0] PRESENT_MASK = 24'h3F_CFFF;
    localparam logic [23:0] DUAL_MASK = 24'h3F_CFF0;
    localparam int PIN_PB = 0;
    localparam int PIN_OPTICAL_RECEIVE_PIN = 1;
    localparam int PIN_OPTICAL_TRANSMIT_PIN = 2;
    localparam int PIN_DEDICATED = 3;
    localparam int PIN_EE_SCK = 4;
    localparam int PIN_EE_SDA = 5;
    localparam int PIN_ENERGY_PULSE_OUT = 6;
    localparam int PIN_VPULSE = 7;

    // ==========================================================
    // special-function register offsets
    localparam logic [7:0] ADDR_DATA0 = 8'h80;
    localparam logic [7:0] ADDR_DATA1 = 8'h90;
    localparam logic [7:0] ADDR_DIR1 = 8'h91;
    localparam logic [7:0] ADDR_DATA2 = 8'hA0;
    localparam logic [7:0] ADDR_DIR2 = 8'hA1;
    localparam logic [7:0] ADDR_DIR0 = 8'hA2;
    localparam logic [7:0] DIR0_MASK = 8'hFE;
    localparam logic [7:0] DIR1_MASK = 8'hCF;
    localparam logic [7:0] DIR2_MASK = 8'h3F;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;

    // ==========================================================
    // resource selector fields in i/o memory
    localparam logic [15:0] SEL_BASE = 16'h2009;
    localparam logic [15:0] SEL_LAST = 16'h200E;
    localparam int SEL_LO_LSB = 0;
    localparam int SEL_HI_LSB = 4;
    localparam logic [2:0] RST_SEL = 3'h0;
    localparam logic [2:0] RES_NONE = 3'h0;
    localparam logic [2:0] RES_RSVD = 3'h1;
    localparam logic [2:0] RES_T0 = 3'h2;
    localparam logic [2:0] RES_T1 = 3'h3;
    localparam logic [2:0] RES_HI_RISE = 3'h4;
    localparam logic [2:0] RES_LO_RISE = 3'h5;
    localparam logic [2:0] RES_HI_FALL = 3'h6;
    localparam logic [2:0] RES_LO_FALL = 3'h7;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } dppr_sfr_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } dppr_xram_req_t;

    typedef struct packed {
        logic optical_uart_used;
        logic ee_select;
        logic energy_pulse_enable;
        logic reactive_pulse_enable;
        logic [4:0] segment_count_setting;
    } dppr_cfg_t;

    typedef struct packed {
        logic energy_pulse_out;
        logic reactive_pulse_out;
        logic ee_sck;
        logic ee_sda_out;
        logic ee_sda_oe;
    } dppr_alt_t;

    typedef struct packed {
        logic counter0_clock;
        logic counter1_clock;
        logic high_priority_interrupt;
        logic low_priority_interrupt;
    } dppr_res_t;

endpackage

// ===== rtl/dppr_selram.sv
// resource selector storage in i/o memory
`timescale 1ns/1ns
module dppr_selram
    import dppr_pkg::*;
#(
    parameter int N = NROUTE
) (
    input wire logic mclk, // system clock
    input wire logic rst, // async reset, high
    input wire dppr_xram_req_t xram, // i/o memory request
    output logic [3*N-1:0] sel, // selector fields, 3 bits per pin
    output logic [7:0] xram_rdata // read answer
);

    typedef struct packed {
        logic [3*N-1:0] sel;
        logic [7:0] rdata;
    } dppr_sel_st_t;

    dppr_sel_st_t st_r;
    dppr_sel_st_t st_nxt;

    function automatic logic hit(input logic [15:0] a);
        hit = (a >= SEL_BASE) && (a <= SEL_LAST);
    endfunction

    function automatic int idx(input logic [15:0] a);
        idx = 2 * int'(a - SEL_BASE);
    endfunction

    always_comb begin
        st_nxt = st_r;
        if (xram.we && hit(xram.addr)) begin
            st_nxt.sel[3*idx(xram.addr) +: 3] = xram.wdata[SEL_LO_LSB +: 3];
            st_nxt.sel[3*idx(xram.addr)+3 +: 3] = xram.wdata[SEL_HI_LSB +: 3];
        end
        if (xram.re) begin
            st_nxt.rdata = 8'h00;
            if (hit(xram.addr)) begin
                st_nxt.rdata[SEL_LO_LSB +: 3] = st_r.sel[3*idx(xram.addr) +: 3];
                st_nxt.rdata[SEL_HI_LSB +: 3] = st_r.sel[3*idx(xram.addr)+3 +: 3];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= '{sel: {N{RST_SEL}}, rdata: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sel = st_r.sel;
    assign xram_rdata = st_r.rdata;

    // ==========================================================
    // checks
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_sel_store;
        xram.we && xram.addr == SEL_BASE |=> sel[2:0] == $past(xram.wdata[2:0]);
    endproperty
    a_sel_store: assert property (p_sel_store) else $error("selector not stored");

    property p_sel_unmapped;
        xram.re && !hit(xram.addr) |=> xram_rdata == 8'h00;
    endproperty
    a_sel_unmapped: assert property (p_sel_unmapped) else $error("unmapped read nonzero");

endmodule

// ===== rtl/dppr_route.sv
// routes pin levels to counter clocks and edge interrupts
`timescale 1ns/1ns
module dppr_route
    import dppr_pkg::*;
#(
    parameter int N = NROUTE
) (
    input wire logic mclk, // system clock
    input wire logic rst, // async reset, high
    input wire logic [N-1:0] level, // actual pin levels
    input wire logic [N-1:0] gp, // pin acts as general-purpose
    input wire logic [3*N-1:0] sel, // selector fields
    output dppr_res_t res // routed resources
);

    typedef struct packed {
        logic hi_rise;
        logic hi_fall;
        logic lo_rise;
        logic lo_fall;
        dppr_res_t res;
    } dppr_route_st_t;

    dppr_route_st_t st_r;
    dppr_route_st_t st_nxt;
    logic [7:0] grp;

    // ==========================================================
    // wired-or per resource code
    always_comb begin
        grp = 8'h00;
        for (int i = 0; i < N; i++) begin
            if (gp[i]) begin
                grp[sel[3*i +: 3]] = grp[sel[3*i +: 3]] | level[i];
            end
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.hi_rise = grp[RES_HI_RISE];
        st_nxt.hi_fall = grp[RES_HI_FALL];
        st_nxt.lo_rise = grp[RES_LO_RISE];
        st_nxt.lo_fall = grp[RES_LO_FALL];
        st_nxt.res.counter0_clock = grp[RES_T0];
        st_nxt.res.counter1_clock = grp[RES_T1];
        st_nxt.res.high_priority_interrupt = (grp[RES_HI_RISE] & ~st_r.hi_rise)
            | (~grp[RES_HI_FALL] & st_r.hi_fall);
        st_nxt.res.low_priority_interrupt = (grp[RES_LO_RISE] & ~st_r.lo_rise)
            | (~grp[RES_LO_FALL] & st_r.lo_fall);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign res = st_r.res;

    // ==========================================================
    // checks
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (rst);

    // independent view: any general pin at high level that selects counter0
    logic t0_hit;

    always_comb begin
        t0_hit = 1'b0;
        for (int i = 0; i < N; i++) begin
            t0_hit = t0_hit | (gp[i] && (sel[3*i +: 3] == RES_T0) && level[i]);
        end
    end

    sequence s_hi_rise;
        !grp[RES_HI_RISE] ##1 grp[RES_HI_RISE];
    endsequence

    property p_hi_rise;
        s_hi_rise |=> res.high_priority_interrupt;
    endproperty
    a_hi_rise: assert property (p_hi_rise) else $error("rising edge lost");

    property p_t0_or;
        ##1 res.counter0_clock == $past(t0_hit);
    endproperty
    a_t0_or: assert property (p_t0_or) else $error("counter0 clock wrong");

endmodule

// ===== dv/dppr_board.sv
// board model: loads and inputs seen at the port pins
`timescale 1ns/1ns
module dppr_board
    import dppr_pkg::*;
(
    input wire logic [NPIN-1:0] pin_out, // drive value from the port
    input wire logic [NPIN-1:0] pin_oe, // drive enable from the port
    input wire logic [NPIN-1:0] ext_level, // level the board puts on undriven pins
    output logic [NPIN-1:0] pin_level // resolved wire level
);
    // a driven pin shows its own drive, so output pulses can be tracked
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ===== dv/testbench.sv
// self-checking bench for the digital pin port router
`timescale 1ns/1ns
module testbench
    import dppr_pkg::*;
;
    logic mclk;
    logic rst;
    dppr_sfr_req_t sfr;
    dppr_xram_req_t xram;
    dppr_cfg_t cfg;
    dppr_alt_t alt;
    dppr_res_t res;
    logic [NPIN-1:0] pin_in;
    logic [NPIN-1:0] pin_out;
    logic [NPIN-1:0] pin_oe;
    logic [NPIN-1:0] seg_enable;
    logic [NPIN-1:0] ext_level;
    logic [7:0] sfr_rdata;
    logic [7:0] xram_rdata;
    logic ee_sda_in;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;

    dppr_top i_dut (.mclk(mclk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata), .xram(xram),
        .xram_rdata(xram_rdata), .cfg(cfg), .alt(alt), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .seg_enable(seg_enable), .ee_sda_in(ee_sda_in), .res(res));
    dppr_board i_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_level(pin_in));

    // ==========================================================
    // shared tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic io, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        if (io)
            xram <= '{addr: a, wdata: d, we: 1'h1, re: 1'h0};
        else
            sfr <= '{addr: a[7:0], wdata: d, we: 1'h1, re: 1'h0};
        @(posedge mclk);
        xram.we <= 1'h0;
        sfr.we <= 1'h0;
    endtask

    task automatic rd_chk(input logic io, input logic [15:0] a, input logic [7:0] e,
        input string n);
        logic [7:0] d;
        @(posedge mclk);
        if (io)
            xram <= '{addr: a, wdata: 8'h00, we: 1'h0, re: 1'h1};
        else
            sfr <= '{addr: a[7:0], wdata: 8'h00, we: 1'h0, re: 1'h1};
        @(posedge mclk);
        xram.re <= 1'h0;
        sfr.re <= 1'h0;
        #1;
        d = io ? xram_rdata : sfr_rdata;
        chk(n, d, e);
    endtask

    // drives pin 8 and counts interrupt pulses that follow
    task automatic edge_cnt(input logic lvl, output int hi, output int lo);
        hi = 0;
        lo = 0;
        @(posedge mclk);
        ext_level[8] <= lvl;
        repeat (8) begin
            @(posedge mclk);
            #1;
            if (res.high_priority_interrupt === 1'h1) hi++;
            if (res.low_priority_interrupt === 1'h1) lo++;
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        rd_chk(0, 16'h00A2, 8'h00, "dir0");
        rd_chk(0, 16'h0091, 8'h00, "dir1");
        rd_chk(0, 16'h00A1, 8'h00, "dir2");
        chk("pin_oe", pin_oe, 24'h00_0000);
        rd_chk(1, 16'h2009, 8'h00, "sel reset");
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr(0, 16'h0091, 8'hFF);
        rd_chk(0, 16'h0091, 8'hCF, "dir1 mask");
        wr(0, 16'h00A1, 8'hFF);
        rd_chk(0, 16'h00A1, 8'h3F, "dir2 mask");
        settle(2);
        chk("oe groups", pin_oe, 24'h3F_CF00);
        wr(0, 16'h0090, 8'h5A);
        settle(3);
        rd_chk(0, 16'h0090, 8'h4A, "pins1");
        wr(0, 16'h0091, 8'h00);
        wr(0, 16'h00A1, 8'h00);
        rd_chk(0, 16'h0095, 8'h00, "unmapped");
        for (int k = 0; k < 6; k++) begin
            wr(1, 16'h2009 + 16'(k), 8'hFF);
            rd_chk(1, 16'h2009 + 16'(k), 8'h77, "sel field");
            wr(1, 16'h2009 + 16'(k), 8'h00);
        end
        rd_chk(1, 16'h2008, 8'h00, "sel below");
        rd_chk(1, 16'h200F, 8'h00, "sel above");
        $display("test regs done");
    endtask

    task automatic t_dir0();
        wr(0, 16'h00A2, 8'hFF);
        rd_chk(0, 16'h00A2, 8'hFE, "dir0 button");
        wr(0, 16'h0080, 8'hA5);
        settle(3);
        chk("oe0", pin_oe[7:0], 8'hFE);
        chk("out0", pin_out[7:1], 7'h52);
        rd_chk(0, 16'h0080, 8'hA4, "pins0");
        @(posedge mclk);
        cfg.energy_pulse_enable <= 1'h1;
        cfg.reactive_pulse_enable <= 1'h1;
        alt.energy_pulse_out <= 1'h1;
        settle(3);
        chk("pulse", pin_out[7:6], 2'h1);
        @(posedge mclk);
        alt.energy_pulse_out <= 1'h0;
        alt.reactive_pulse_out <= 1'h1;
        settle(3);
        chk("pulse swap", pin_out[7:6], 2'h2);
        wr(0, 16'h00A2, 8'h3E);
        settle(2);
        chk("pulse needs dir", pin_oe[7:6], 2'h0);
        @(posedge mclk);
        cfg.optical_uart_used <= 1'h1;
        settle(3);
        chk("optical used", pin_oe[2:1], 2'h0);
        @(posedge mclk);
        cfg.optical_uart_used <= 1'h0;
        cfg.energy_pulse_enable <= 1'h0;
        cfg.reactive_pulse_enable <= 1'h0;
        settle(3);
        chk("optical free", pin_oe[2:1], 2'h3);
        wr(0, 16'h00A2, 8'h00);
        $display("test dir0 done");
    endtask

    task automatic t_ee();
        @(posedge mclk);
        cfg.ee_select <= 1'h1;
        alt.ee_sck <= 1'h1;
        alt.ee_sda_oe <= 1'h1;
        ext_level[5] <= 1'h1;
        settle(3);
        chk("ee oe", pin_oe[5:4], 2'h3);
        chk("ee out", pin_out[5:4], 2'h1);
        @(posedge mclk);
        alt.ee_sda_oe <= 1'h0;
        settle(4);
        chk("ee sda in", ee_sda_in, 1'h1);
        chk("ee sda free", pin_oe[5], 1'h0);
        @(posedge mclk);
        cfg.ee_select <= 1'h0;
        ext_level[5] <= 1'h0;
        settle(3);
        $display("test ee done");
    endtask

    task automatic t_route();
        int hi;
        int lo;
        for (int c = 0; c < 8; c++) begin
            wr(1, 16'h200D, {5'h00, c[2:0]});
            edge_cnt(1'h1, hi, lo);
            chk("rise high", 24'(hi), c == 4);
            chk("rise low", 24'(lo), c == 5);
            chk("counter0", res.counter0_clock, c == 2);
            chk("counter1", res.counter1_clock, c == 3);
            edge_cnt(1'h0, hi, lo);
            chk("fall high", 24'(hi), c == 6);
            chk("fall low", 24'(lo), c == 7);
        end
        $display("test route done");
    endtask

    task automatic t_or_seg();
        wr(1, 16'h200D, 8'h22);
        wr(0, 16'h0090, 8'h00);
        wr(0, 16'h0091, 8'h02);
        settle(4);
        chk("or idle", res.counter0_clock, 1'h0);
        wr(0, 16'h0090, 8'h02);
        settle(4);
        chk("tracks output", res.counter0_clock, 1'h1);
        wr(0, 16'h0090, 8'h00);
        @(posedge mclk);
        ext_level[8] <= 1'h1;
        settle(4);
        chk("or of pins", res.counter0_clock, 1'h1);
        wr(0, 16'h0091, 8'h00);
        @(posedge mclk);
        cfg.segment_count_setting <= 5'h05;
        settle(4);
        chk("segments", seg_enable[9:4], 6'h1F);
        chk("segment no route", res.counter0_clock, 1'h0);
        @(posedge mclk);
        cfg.segment_count_setting <= 5'h04;
        settle(4);
        chk("general routes", res.counter0_clock, 1'h1);
        $display("test or_seg done");
    endtask

    // ==========================================================
    // clock, timeout and main sequence
    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            $display("timeout after %0d cycles", cyc);
            close_out();
        end
    end

    initial begin
        rst = 1'h1;
        sfr = '0;
        xram = '0;
        cfg = '0;
        alt = '0;
        ext_level = '0;
        repeat (4) @(posedge mclk);
        rst <= 1'h0;
        t_reset();
        t_regs();
        t_dir0();
        t_ee();
        t_route();
        t_or_seg();
        close_out();
    end
endmodule
